// ===== hdl/oemr_output_enable_mode_regs.sv
// Output driver enable and mode register bank with its pin-control decode.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Diff enable bit n drives pair n.
// - Single enable bits 3:0 enable outputs.
// - Mode 000 is off; 001..011 select single-ended outputs.
// - Mode 100 makes odd inverted even.
// - 101 is HCSL, 110 is PECL.
// - Lower register bits 6:4 control outputs 2,3.
// - Upper bits 2:0 control outputs 4,5.
// - Upper bits 6:4 control outputs 6,7.
// - Differential pair ignores odd source select.
module oemr_output_enable_mode_regs
(
   input  wire logic       clk,
   input  wire logic       sys_rst,
   input  wire logic       regWrEn,
   input  wire logic       regRdEn,
   input  wire logic [7:0] regAddr,
   input  wire logic [7:0] regWrData,
   output logic      [7:0] regRdData,
   output logic            regHit,
   output logic      [7:0] precisionDiffPairOe,
   output logic      [3:0] precisionSingleOutputOe,
   output logic      [7:0] configurableClockOutputOe,
   output logic      [7:0] configurableClockOutputInvert,
   output logic      [7:0] configurableClockOutputSrcIgnore,
   output logic      [7:0] configurableClockOutputDiff,
   output logic      [7:0] configurableClockOutputDrvType,
   output logic      [7:0] outputSourceSelectUpper
);

   // ****************************************
   // Register file
   // ****************************************
   logic [7:0] diffEn_r;
   logic [7:0] diffEn_nxt;
   logic [7:0] singleEn_r;
   logic [7:0] singleEn_nxt;
   logic [7:0] modeUpper_r;
   logic [7:0] modeUpper_nxt;
   logic [7:0] modeLower_r;
   logic [7:0] modeLower_nxt;
   logic [7:0] srcUpper_r;
   logic [7:0] srcUpper_nxt;
   // Reserved bits are stored as zero, so read-back needs no masking of its own.
   logic [7:0] rdData_nxt;

   always_comb
   begin
      diffEn_nxt    = diffEn_r;
      singleEn_nxt  = singleEn_r;
      modeUpper_nxt = modeUpper_r;
      modeLower_nxt = modeLower_r;
      srcUpper_nxt  = srcUpper_r;
      if (regWrEn)
      begin
         unique case (regAddr)
            oemr_pkg::DIFF_EN_OFS:    diffEn_nxt    = regWrData;
            oemr_pkg::SINGLE_EN_OFS:  singleEn_nxt  = regWrData & oemr_pkg::SINGLE_EN_MASK;
            oemr_pkg::MODE_UPPER_OFS: modeUpper_nxt = regWrData & oemr_pkg::MODE_MASK;
            oemr_pkg::MODE_LOWER_OFS: modeLower_nxt = regWrData & oemr_pkg::MODE_MASK;
            oemr_pkg::SRC_UPPER_OFS:  srcUpper_nxt  = regWrData;
            // Unmapped writes ignored.
            // A stray address leaves every register as it was, never a neighbour.
            default:                  diffEn_nxt    = diffEn_r;
         endcase
      end
      // Read data holds between reads, so a slow host may sample it late.
      rdData_nxt = regRdData;
      if (regRdEn)
      begin
         unique case (regAddr)
            oemr_pkg::DIFF_EN_OFS:    rdData_nxt = diffEn_r;
            oemr_pkg::SINGLE_EN_OFS:  rdData_nxt = singleEn_r;
            oemr_pkg::MODE_UPPER_OFS: rdData_nxt = modeUpper_r;
            oemr_pkg::MODE_LOWER_OFS: rdData_nxt = modeLower_r;
            oemr_pkg::SRC_UPPER_OFS:  rdData_nxt = srcUpper_r;
            default:                  rdData_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         diffEn_r    <= oemr_pkg::DIFF_EN_RST;
         singleEn_r  <= oemr_pkg::SINGLE_EN_RST;
         modeUpper_r <= oemr_pkg::MODE_UPPER_RST;
         modeLower_r <= oemr_pkg::MODE_LOWER_RST;
         srcUpper_r  <= oemr_pkg::SRC_UPPER_RST;
         regRdData   <= 8'h00;
      end
      else
      begin
         diffEn_r    <= diffEn_nxt;
         singleEn_r  <= singleEn_nxt;
         modeUpper_r <= modeUpper_nxt;
         modeLower_r <= modeLower_nxt;
         srcUpper_r  <= srcUpper_nxt;
         regRdData   <= rdData_nxt;
      end
   end

   // ****************************************
   // Bus address decode
   // ****************************************
   // Combinational so the host sees the hit while it still drives the address.
   assign regHit = (regAddr >= oemr_pkg::DIFF_EN_OFS) && (regAddr <= oemr_pkg::SRC_UPPER_OFS);

   // ****************************************
   // Driver control decode
   // ****************************************
   // Outputs are decoded from registered state only, so pins never glitch on bus activity.
   logic [2:0] pairMode [4];
   logic [7:0] cfgOe_nxt;
   logic [7:0] cfgInv_nxt;
   logic [7:0] cfgDiff_nxt;
   logic [7:0] cfgDrv_nxt;
   logic [7:0] diffOe_nxt;
   logic [3:0] singleOe_nxt;
   logic [7:0] srcSel_nxt;

   always_comb
   begin
      diffOe_nxt   = diffEn_r;
      singleOe_nxt = singleEn_r[3:0];
      srcSel_nxt   = srcUpper_r;
      pairMode[0] = modeLower_r[oemr_pkg::MODE_LO_POS +: oemr_pkg::MODE_W];
      pairMode[1] = modeLower_r[oemr_pkg::MODE_HI_POS +: oemr_pkg::MODE_W];
      pairMode[2] = modeUpper_r[oemr_pkg::MODE_LO_POS +: oemr_pkg::MODE_W];
      pairMode[3] = modeUpper_r[oemr_pkg::MODE_HI_POS +: oemr_pkg::MODE_W];
      cfgOe_nxt   = 8'h00;
      cfgInv_nxt  = 8'h00;
      cfgDiff_nxt = 8'h00;
      cfgDrv_nxt  = 8'h00;
      // Each pair decodes on its own, so rewriting one field never disturbs another.
      for (int p = 0; p < 4; p++)
      begin
         unique case (pairMode[p])
            oemr_pkg::MODE_EVEN_ONLY: cfgOe_nxt[2*p]   = 1'b1;
            oemr_pkg::MODE_ODD_ONLY:  cfgOe_nxt[2*p+1] = 1'b1;
            oemr_pkg::MODE_BOTH:      cfgOe_nxt[2*p +: 2] = 2'h3;
            oemr_pkg::MODE_COMPL:
            begin
               cfgOe_nxt[2*p +: 2] = 2'h3;
               cfgInv_nxt[2*p+1]   = 1'b1;
            end
            oemr_pkg::MODE_HCSL:
            begin
               cfgOe_nxt[2*p +: 2]   = 2'h3;
               cfgInv_nxt[2*p+1]     = 1'b1;
               cfgDiff_nxt[2*p +: 2] = 2'h3;
               cfgDrv_nxt[2*p +: 2]  = oemr_pkg::DRV_HCSL;
            end
            oemr_pkg::MODE_PECL:
            begin
               cfgOe_nxt[2*p +: 2]   = 2'h3;
               cfgInv_nxt[2*p+1]     = 1'b1;
               cfgDiff_nxt[2*p +: 2] = 2'h3;
               cfgDrv_nxt[2*p +: 2]  = oemr_pkg::DRV_PECL;
            end
            // Undefined code disables.
            // Code 111 has no defined meaning, so parking the pair off is the safe choice.
            default:                  cfgOe_nxt[2*p +: 2] = 2'h0;
         endcase
      end
   end

   // ****************************************
   // Pin control registers
   // ****************************************
   // Drivers stay tristated while reset is held and take the default enables one edge later.
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         precisionDiffPairOe              <= 8'h00;
         precisionSingleOutputOe          <= 4'h0;
         configurableClockOutputOe        <= 8'h00;
         configurableClockOutputInvert    <= 8'h00;
         configurableClockOutputSrcIgnore <= 8'h00;
         configurableClockOutputDiff      <= 8'h00;
         configurableClockOutputDrvType   <= 8'h00;
         outputSourceSelectUpper          <= 8'h00;
      end
      else
      begin
         precisionDiffPairOe              <= diffOe_nxt;
         precisionSingleOutputOe          <= singleOe_nxt;
         configurableClockOutputOe        <= cfgOe_nxt;
         configurableClockOutputInvert    <= cfgInv_nxt;
         configurableClockOutputSrcIgnore <= cfgInv_nxt;
         configurableClockOutputDiff      <= cfgDiff_nxt;
         configurableClockOutputDrvType   <= cfgDrv_nxt;
         // Source select is stored only; the clock mux itself sits outside this bank.
         outputSourceSelectUpper          <= srcSel_nxt;
      end
   end

endmodule

`default_nettype wire

// ===== inc/oemr_pkg.sv
// Package of offsets, field positions, reset values and mode codes for the output enable bank.
package oemr_pkg;
   localparam logic [7:0] DIFF_EN_OFS     = 8'hb0;
   localparam logic [7:0] SINGLE_EN_OFS   = 8'hb1;
   localparam logic [7:0] MODE_UPPER_OFS  = 8'hb2;
   localparam logic [7:0] MODE_LOWER_OFS  = 8'hb3;
   localparam logic [7:0] SRC_UPPER_OFS   = 8'hb4;

   localparam logic [7:0] DIFF_EN_RST     = 8'h55;
   localparam logic [7:0] SINGLE_EN_RST   = 8'h0f;
   localparam logic [7:0] MODE_UPPER_RST  = 8'h00;
   localparam logic [7:0] MODE_LOWER_RST  = 8'h00;
   localparam logic [7:0] SRC_UPPER_RST   = 8'h00;

   localparam logic [7:0] SINGLE_EN_MASK  = 8'h0f;
   localparam logic [7:0] MODE_MASK       = 8'h77;
   localparam int         MODE_LO_POS     = 0;
   localparam int         MODE_HI_POS     = 4;
   localparam int         MODE_W          = 3;

   localparam logic [2:0] MODE_OFF        = 3'h0;
   localparam logic [2:0] MODE_EVEN_ONLY  = 3'h1;
   localparam logic [2:0] MODE_ODD_ONLY   = 3'h2;
   localparam logic [2:0] MODE_BOTH       = 3'h3;
   localparam logic [2:0] MODE_COMPL      = 3'h4;
   localparam logic [2:0] MODE_HCSL       = 3'h5;
   localparam logic [2:0] MODE_PECL       = 3'h6;

   localparam logic [1:0] DRV_CMOS        = 2'h0;
   localparam logic [1:0] DRV_HCSL        = 2'h1;
   localparam logic [1:0] DRV_PECL        = 2'h2;
endpackage

// ===== sim/oemr_output_enable_mode_regs_tb.sv
// Self-checking bench for the output enable and mode register bank.
`timescale 1ns/1ps
`default_nettype none
module oemr_output_enable_mode_regs_tb;
   logic       clk, sys_rst, regWrEn, regRdEn, regHit;
   logic [7:0] regAddr, regWrData, regRdData, dOe, cOe, cInv, cIgn, cDif, cDrv, srcSel;
   logic [7:0] eo, ei, ed, ev;
   logic [3:0] sOe;
   logic [2:0] f [4];
   int         fail_count, checks, m, p;
   oemr_output_enable_mode_regs u_dut (.clk, .sys_rst, .regWrEn, .regRdEn, .regAddr,
      .regWrData, .regRdData, .regHit, .precisionDiffPairOe(dOe),
      .precisionSingleOutputOe(sOe), .configurableClockOutputOe(cOe),
      .configurableClockOutputInvert(cInv), .configurableClockOutputSrcIgnore(cIgn),
      .configurableClockOutputDiff(cDif), .configurableClockOutputDrvType(cDrv),
      .outputSourceSelectUpper(srcSel));
   always #10 clk = ~clk;
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("BAD %0t seen %h want %h", $time, seen, exp);
      end
   endtask
   // Strobes are held one cycle, so back-to-back calls leave an idle cycle between.
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk) #1 {regWrEn, regAddr, regWrData} = {1'b1, a, d};
      @(posedge clk) #1 regWrEn = 0;
   endtask
   task rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk) #1 {regRdEn, regAddr} = {1'b1, a};
      @(posedge clk) #1 regRdEn = 0;
      chk(regRdData, e);
   endtask
   task wrap_up;
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial
   begin
      {sys_rst, clk, regWrEn, regRdEn, regAddr, regWrData} = 20'h80000;
      repeat (4) @(posedge clk);
      #1 sys_rst = 0;
      rd(8'hb0, 8'h55);
      rd(8'hb1, 8'h0f);
      rd(8'hb2, 8'h00);
      rd(8'hb3, 8'h00);
      rd(8'hb4, 8'h00);
      chk({7'h0, regHit}, 8'h01);
      chk(dOe, 8'h55);
      chk({4'h0, sOe}, 8'h0f);
      chk(cOe, 8'h00);
      $display("reset test done");
      wr(8'hb0, 8'ha6);
      wr(8'hb1, 8'hf6);
      wr(8'hb4, 8'h3c);
      wr(8'hb5, 8'hff);
      rd(8'hb1, 8'h06);
      rd(8'hb5, 8'h00);
      chk({7'h0, regHit}, 8'h00);
      rd(8'haf, 8'h00);
      chk({7'h0, regHit}, 8'h00);
      rd(8'hb0, 8'ha6);
      rd(8'hb4, 8'h3c);
      chk(dOe, 8'ha6);
      chk({4'h0, sOe}, 8'h06);
      chk(srcSel, 8'h3c);
      $display("enable test done");
      for (m = 0; m < 8; m++)
      begin
         for (p = 0; p < 4; p++)
            f[p] = 3'(m + p);
         wr(8'hb3, {1'b1, f[1], 1'b1, f[0]});
         wr(8'hb2, {1'b1, f[3], 1'b1, f[2]});
         rd(8'hb3, {1'b0, f[1], 1'b0, f[0]});
         rd(8'hb2, {1'b0, f[3], 1'b0, f[2]});
         for (p = 0; p < 4; p++)
         begin
            eo[2*p+:2] = (f[p] == 3'h1) ? 2'h1 : (f[p] == 3'h2) ? 2'h2 :
                         (f[p] == 3'h0 || f[p] == 3'h7) ? 2'h0 : 2'h3;
            ei[2*p+:2] = {f[p] inside {3'h4, 3'h5, 3'h6}, 1'b0};
            ed[2*p+:2] = {2{f[p] inside {3'h5, 3'h6}}};
            ev[2*p+:2] = (f[p] == 3'h5) ? 2'h1 : (f[p] == 3'h6) ? 2'h2 : 2'h0;
         end
         chk(cOe, eo);
         chk(cInv, ei);
         chk(cIgn, ei);
         chk(cDif, ed);
         chk(cDrv, ev);
      end
      $display("mode test done");
      @(posedge clk) #1 sys_rst = 1;
      repeat (2) @(posedge clk);
      #1 sys_rst = 0;
      rd(8'hb0, 8'h55);
      rd(8'hb2, 8'h00);
      rd(8'hb3, 8'h00);
      chk(cOe, 8'h00);
      chk(dOe, 8'h55);
      $display("second reset test done");
      wrap_up;
   end
   initial
   begin
      #20000 fail_count++;
      wrap_up;
   end
endmodule
`default_nettype wire

// ===== sim/oemr_properties.sv
// Port checker for the output enable and mode register bank.
`timescale 1ns/1ps
`default_nettype none
module oemr_checker
(
   input wire logic       clk,
   input wire logic       sys_rst,
   input wire logic       regWrEn,
   input wire logic       regRdEn,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic [7:0] regRdData,
   input wire logic [7:0] precisionDiffPairOe,
   input wire logic [3:0] precisionSingleOutputOe,
   input wire logic [7:0] configurableClockOutputOe,
   input wire logic [7:0] configurableClockOutputSrcIgnore,
   input wire logic [7:0] configurableClockOutputDiff,
   input wire logic [7:0] configurableClockOutputDrvType
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   diff_follow_a: assert property (regWrEn && regAddr == 8'hb0 |=> ##1
      precisionDiffPairOe == $past(regWrData, 2)) else $error("Diff enable wrong.");
   single_follow_a: assert property (regWrEn && regAddr == 8'hb1 |=> ##1
      precisionSingleOutputOe == $past(regWrData[3:0], 2)) else $error("Single enable wrong.");
   unmapped_zero_a: assert property (regRdEn && !(regAddr inside {[8'hb0:8'hb4]})
      |=> regRdData == 8'h00) else $error("Unmapped read not zero.");
   diff_ignore_a: assert property ((configurableClockOutputDiff & 8'haa
      & ~configurableClockOutputSrcIgnore) == 8'h00) else $error("Diff odd not ignored.");
   lower_single_a: assert property (regWrEn && regAddr == 8'hb3 && regWrData[2:0] == 3'h1
      |=> ##1 configurableClockOutputOe[1:0] == 2'h1) else $error("Even-only wrong.");
   lower_pecl_a: assert property (regWrEn && regAddr == 8'hb3 && regWrData[6:4] == 3'h6
      |=> ##1 configurableClockOutputDrvType[3:2] == 2'h2) else $error("PECL pair wrong.");
   upper_off_a: assert property (regWrEn && regAddr == 8'hb2 && regWrData[2:0] == 3'h7
      |=> ##1 configurableClockOutputOe[5:4] == 2'h0) else $error("Mode 7 not off.");
   upper_hcsl_a: assert property (regWrEn && regAddr == 8'hb2 && regWrData[6:4] == 3'h5
      |=> ##1 configurableClockOutputDiff[7:6] == 2'h3) else $error("HCSL pair wrong.");
endmodule
bind oemr_output_enable_mode_regs oemr_checker u_chk (.clk, .sys_rst, .regWrEn, .regRdEn,
   .regAddr, .regWrData, .regRdData, .precisionDiffPairOe, .precisionSingleOutputOe,
   .configurableClockOutputOe, .configurableClockOutputSrcIgnore,
   .configurableClockOutputDiff, .configurableClockOutputDrvType);
`default_nettype wire
